// file: common/tmr2_pkg.sv
// Package of register map, field positions and encodings for the 8-bit timer
package tmr2_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam logic [4:0] TMR2_OFS_CTRL_A   = 5'h00;
  localparam logic [4:0] TMR2_OFS_CTRL_B   = 5'h04;
  localparam logic [4:0] TMR2_OFS_COUNT    = 5'h08;
  localparam logic [4:0] TMR2_OFS_CMP_A    = 5'h0c;
  localparam logic [4:0] TMR2_OFS_CMP_B    = 5'h10;
  localparam logic [4:0] TMR2_OFS_IRQ_MASK = 5'h14;
  localparam logic [4:0] TMR2_OFS_IRQ_FLAG = 5'h18;
  localparam logic [4:0] TMR2_OFS_ASYNC    = 5'h1c;
  // Control register A fields
  localparam int TMR2_CA_WGM_LO = 0;  // Two low waveform mode bits
  localparam int TMR2_CA_COM_B  = 4;  // Output action mode B, 2 bits
  localparam int TMR2_CA_COM_A  = 6;  // Output action mode A, 2 bits
  // Control register B fields
  localparam int TMR2_CB_CS     = 0;  // Clock select, 3 bits
  localparam int TMR2_CB_WGM_HI = 3;  // Top waveform mode bit
  localparam int TMR2_CB_FOC_B  = 6;  // Force strobe B, write only
  localparam int TMR2_CB_FOC_A  = 7;  // Force strobe A, write only
  // Flag and mask bit positions
  localparam int TMR2_IRQ_OVF   = 0;
  localparam int TMR2_IRQ_A     = 1;
  localparam int TMR2_IRQ_B     = 2;
  // Async status register field
  localparam int TMR2_AS_SEL    = 5;
  // Count limits
  localparam logic [7:0] TMR2_BOTTOM = 8'h00;
  localparam logic [7:0] TMR2_MAX    = 8'hff;
  // Reset values
  localparam logic [7:0] TMR2_RST_BYTE = 8'h00;
  // Waveform modes
  localparam logic [2:0] TMR2_WGM_NORMAL  = 3'h0;
  localparam logic [2:0] TMR2_WGM_PC_MAX  = 3'h1;
  localparam logic [2:0] TMR2_WGM_CTC     = 3'h2;
  localparam logic [2:0] TMR2_WGM_FAST_MX = 3'h3;
  localparam logic [2:0] TMR2_WGM_PC_OCA  = 3'h5;
  localparam logic [2:0] TMR2_WGM_FAST_OA = 3'h7;
  // Output action modes
  localparam logic [1:0] TMR2_COM_NONE   = 2'h0;
  localparam logic [1:0] TMR2_COM_TOGGLE = 2'h1;
  localparam logic [1:0] TMR2_COM_CLEAR  = 2'h2;
  localparam logic [1:0] TMR2_COM_SET    = 2'h3;
  // Prescaler tap masks (divisor minus one) indexed by clock select
  localparam int TMR2_PRE_W = 10;
  localparam logic [9:0] TMR2_TAP_1    = 10'h000;
  localparam logic [9:0] TMR2_TAP_8    = 10'h007;
  localparam logic [9:0] TMR2_TAP_32   = 10'h01f;
  localparam logic [9:0] TMR2_TAP_64   = 10'h03f;
  localparam logic [9:0] TMR2_TAP_128  = 10'h07f;
  localparam logic [9:0] TMR2_TAP_256  = 10'h0ff;
  localparam logic [9:0] TMR2_TAP_1024 = 10'h3ff;
  localparam logic [2:0] TMR2_CS_OFF   = 3'h0;
endpackage

// file: core/tmr2_timer.sv
// 8-bit timer/counter with two compare channels and an Avalon-MM register slave
//
// Chosen here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps

module tmr2_timer
  import tmr2_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic        oscPinIn,
  output logic             oscPinOut,
  input  wire logic [2:0]  irqAck,
  output logic [2:0]       irqReq,
  output logic             waveOutA,
  output logic             waveOutB
);

  typedef struct packed {
    logic [7:0]      count;
    logic            down;
    logic [1:0][7:0] cmp;
    logic [1:0][7:0] cmpBuf;
    logic [2:0]      wgm;
    logic [1:0][1:0] com;
    logic [2:0]      clkSel;
    logic            asyncSel;
    logic [2:0]      mask;
    logic [2:0]      flags;
    logic            block;
    logic            ack;
    logic [7:0]      rdata;
    logic [9:0]      pre;
    logic [2:0]      oscSync;
    logic            oscOut;
    logic [1:0]      oc;
  } tmr2_state_t;

  tmr2_state_t st;
  tmr2_state_t next_st;

  logic       pwm;
  logic       fast;
  logic [7:0] top;
  logic       baseTick;
  logic       tick;
  logic [9:0] tapMask;
  logic       cpuWr;
  logic       cpuRd;
  logic       wrEn;
  logic [7:0] wByte;
  logic [1:0] match;
  logic       atTop;
  logic       atBottom;
  logic [2:0] flagSet;

  // Mode decode
  assign pwm  = st.wgm[0];
  assign fast = st.wgm[1] & st.wgm[0];
  assign top  = st.wgm[2] ? st.cmp[0] : TMR2_MAX;
  assign atTop    = (st.count == top);
  assign atBottom = (st.count == TMR2_BOTTOM);

  // Bus handshake: one wait cycle, then the access completes
  assign waitrequest = (read | write) & ~st.ack;
  assign cpuWr       = write & st.ack;
  assign cpuRd       = read & ~st.ack;
  assign wrEn        = cpuWr & byteenable[0];
  assign wByte       = writedata[7:0];
  assign readdata    = {24'h000000, st.rdata};
  assign oscPinOut   = st.oscOut;
  assign waveOutA    = st.oc[0];
  assign waveOutB    = st.oc[1];
  assign irqReq      = st.flags & st.mask;

  // Prescaler tap selection
  always_comb
  begin
    case (st.clkSel)
      3'h1:    tapMask = TMR2_TAP_1;
      3'h2:    tapMask = TMR2_TAP_8;
      3'h3:    tapMask = TMR2_TAP_32;
      3'h4:    tapMask = TMR2_TAP_64;
      3'h5:    tapMask = TMR2_TAP_128;
      3'h6:    tapMask = TMR2_TAP_256;
      3'h7:    tapMask = TMR2_TAP_1024;
      default: tapMask = TMR2_TAP_1;
    endcase
  end

  // base source: bus clock or synchronised oscillator rising edge
  // edge taken from the second and third stages only
  assign baseTick = st.asyncSel ? (st.oscSync[1] & ~st.oscSync[2]) : 1'b1;
  // no tick with clock select zero
  assign tick = (st.clkSel != TMR2_CS_OFF) & baseTick & ((st.pre & tapMask) == tapMask);

  // continuous comparison per channel, gated by the write block
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      match[i] = (st.count == st.cmp[i]) & ~st.block;
    end
  end

  // Next-state logic
  always_comb
  begin
    next_st = st;
    flagSet = 3'h0;
    next_st.ack = (read | write) & ~st.ack;
    next_st.oscSync = {st.oscSync[1:0], oscPinIn};
    next_st.oscOut = ~st.oscSync[1];
    if (baseTick)
    begin
      next_st.pre = st.pre + 10'h001;
    end

    // Read data captured on the first cycle of a read
    if (cpuRd)
    begin
      case (address)
        TMR2_OFS_CTRL_A:   next_st.rdata = {st.com[0], st.com[1], 2'b00, st.wgm[1:0]};
        TMR2_OFS_CTRL_B:   next_st.rdata = {4'h0, st.wgm[2], st.clkSel};
        TMR2_OFS_COUNT:    next_st.rdata = st.count;
        TMR2_OFS_CMP_A:    next_st.rdata = pwm ? st.cmpBuf[0] : st.cmp[0];
        TMR2_OFS_CMP_B:    next_st.rdata = pwm ? st.cmpBuf[1] : st.cmp[1];
        TMR2_OFS_IRQ_MASK: next_st.rdata = {5'h00, st.mask};
        TMR2_OFS_IRQ_FLAG: next_st.rdata = {5'h00, st.flags};
        TMR2_OFS_ASYNC:    next_st.rdata = {2'b00, st.asyncSel, 5'h00};
        default:           next_st.rdata = TMR2_RST_BYTE;
      endcase
    end

    // Block expires on the next tick after a count write
    if (tick)
    begin
      next_st.block = 1'b0;
    end

    // Counting and overflow
    if (tick)
    begin
      case (st.wgm)
        TMR2_WGM_PC_MAX, TMR2_WGM_PC_OCA:
        begin
          // Dual slope: turn at top, turn at bottom
          if (!st.down)
          begin
            if (atTop)
            begin
              next_st.down  = 1'b1;
              next_st.count = st.count - 8'h01;
              next_st.cmp   = st.cmpBuf;
            end
            else
            begin
              next_st.count = st.count + 8'h01;
            end
          end
          else
          begin
            if (atBottom)
            begin
              next_st.down  = 1'b0;
              next_st.count = st.count + 8'h01;
            end
            else
            begin
              next_st.count = st.count - 8'h01;
            end
            // overflow flag as the count reaches bottom in dual slope
            if (st.count == 8'h01)
            begin
              next_st.flags[TMR2_IRQ_OVF] = 1'b1;
              flagSet[TMR2_IRQ_OVF]       = 1'b1;
            end
          end
        end
        TMR2_WGM_FAST_MX, TMR2_WGM_FAST_OA:
        begin
          next_st.down = 1'b0;
          if (atTop)
          begin
            next_st.count = TMR2_BOTTOM;
            next_st.flags[TMR2_IRQ_OVF] = 1'b1;
            flagSet[TMR2_IRQ_OVF]       = 1'b1;
            // buffer update as count returns to bottom
            next_st.cmp = st.cmpBuf;
          end
          else
          begin
            next_st.count = st.count + 8'h01;
          end
        end
        TMR2_WGM_CTC:
        begin
          next_st.down = 1'b0;
          // clear on match with compare A
          if (match[0])
          begin
            next_st.count = TMR2_BOTTOM;
          end
          else
          begin
            next_st.count = st.count + 8'h01;
          end
          if (st.count == TMR2_MAX)
          begin
            next_st.flags[TMR2_IRQ_OVF] = 1'b1;
            flagSet[TMR2_IRQ_OVF]       = 1'b1;
          end
        end
        default:
        begin
          // normal counting with wrap and overflow
          next_st.down  = 1'b0;
          next_st.count = st.count + 8'h01;
          if (st.count == TMR2_MAX)
          begin
            next_st.flags[TMR2_IRQ_OVF] = 1'b1;
            flagSet[TMR2_IRQ_OVF]       = 1'b1;
          end
        end
      endcase
    end

    // Compare channels: flags and output state
    for (int i = 0; i < 2; i++)
    begin
      // flag sets on the tick that ends the matching cycle
      if (tick && match[i])
      begin
        next_st.flags[TMR2_IRQ_A + i] = 1'b1;
        flagSet[TMR2_IRQ_A + i]       = 1'b1;
      end
      // output action read live; mode zero does nothing
      if (tick && match[i] && !pwm)
      begin
        case (st.com[i])
          TMR2_COM_TOGGLE: next_st.oc[i] = ~st.oc[i];
          TMR2_COM_CLEAR:  next_st.oc[i] = 1'b0;
          TMR2_COM_SET:    next_st.oc[i] = 1'b1;
          default:         next_st.oc[i] = st.oc[i];
        endcase
      end
      else if (tick && pwm && st.com[i][1])
      begin
        // Fast: action on match, opposite at bottom; dual slope: direction picks
        if (match[i])
        begin
          next_st.oc[i] = st.com[i][0] ^ (st.down & ~fast);
        end
        else if (fast && atTop)
        begin
          next_st.oc[i] = ~st.com[i][0];
        end
      end
    end

    // Software writes take effect on the completing cycle
    if (wrEn)
    begin
      case (address)
        TMR2_OFS_CTRL_A:
        begin
          // output states untouched by mode change
          next_st.wgm[1:0] = wByte[TMR2_CA_WGM_LO +: 2];
          next_st.com[1]   = wByte[TMR2_CA_COM_B +: 2];
          next_st.com[0]   = wByte[TMR2_CA_COM_A +: 2];
        end
        TMR2_OFS_CTRL_B:
        begin
          // top mode bit lives in control B
          next_st.clkSel = wByte[TMR2_CB_CS +: 3];
          next_st.wgm[2] = wByte[TMR2_CB_WGM_HI];
          // forced match in non-PWM modes, no flag, no clear
          for (int i = 0; i < 2; i++)
          begin
            if (!pwm && wByte[TMR2_CB_FOC_A - i])
            begin
              case (st.com[i])
                TMR2_COM_TOGGLE: next_st.oc[i] = ~st.oc[i];
                TMR2_COM_CLEAR:  next_st.oc[i] = 1'b0;
                TMR2_COM_SET:    next_st.oc[i] = 1'b1;
                default:         next_st.oc[i] = st.oc[i];
              endcase
            end
          end
        end
        TMR2_OFS_COUNT:
        begin
          // write wins over count or clear
          next_st.count = wByte;
          // block matches on the next tick
          next_st.block = 1'b1;
        end
        TMR2_OFS_CMP_A:
        begin
          // buffered in PWM modes, direct otherwise
          if (pwm)
            next_st.cmpBuf[0] = wByte;
          else
            next_st.cmp[0] = wByte;
        end
        TMR2_OFS_CMP_B:
        begin
          if (pwm)
            next_st.cmpBuf[1] = wByte;
          else
            next_st.cmp[1] = wByte;
        end
        TMR2_OFS_IRQ_MASK: next_st.mask = wByte[2:0];
        TMR2_OFS_ASYNC:    next_st.asyncSel = wByte[TMR2_AS_SEL];
        default:           next_st.mask = next_st.mask;
      endcase
    end

    // clear by service or written one; hardware set wins
    for (int i = 0; i < 3; i++)
    begin
      if ((irqAck[i] || (wrEn && address == TMR2_OFS_IRQ_FLAG && wByte[i]))
          && !flagSet[i])
      begin
        next_st.flags[i] = 1'b0;
      end
    end
    // Keep buffer tracking active value outside PWM so a mode switch starts consistent
    if (!pwm)
    begin
      next_st.cmpBuf = next_st.cmp;
    end
  end

  // state register with asynchronous reset to zero
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule

// file: sim/tmr2_cpu_model.sv
// Processor-side model that services pending timer interrupt requests
`timescale 1ns/1ps
module tmr2_cpu_model
  import tmr2_pkg::*;
#(
  parameter int DELAY = 3
)
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       enable,
  input  wire logic [2:0] irqReq,
  output logic      [2:0] irqAck
);
  int waitCnt;

  // Acknowledge the lowest pending request after a service delay
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      waitCnt <= 0;
      irqAck  <= 3'h0;
    end
    else
    begin
      irqAck <= 3'h0;
      if (!enable || irqReq == 3'h0 || irqAck != 3'h0)
        waitCnt <= 0;
      else if (waitCnt == DELAY)
      begin
        irqAck  <= irqReq & ~(irqReq - 3'h1); // One-cycle service pulse
        waitCnt <= 0;
      end
      else
        waitCnt <= waitCnt + 1;
    end
  end
endmodule

// file: sim/tmr2_checker.sv
// Port relation checks for the timer register slave and its outputs
`timescale 1ns/1ps
module tmr2_checker
  import tmr2_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic [4:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        oscPinIn,
  input wire logic        oscPinOut,
  input wire logic [2:0]  irqAck,
  input wire logic [2:0]  irqReq,
  input wire logic        waveOutA,
  input wire logic        waveOutB
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Bus handshake, read data, interrupt, reset output and oscillator relations
  a_wait_answer: assert property ((read | write) && waitrequest |=> !waitrequest)
    else $error("request not answered in the next cycle");
  a_wait_idle: assert property (!(read | write) |-> !waitrequest)
    else $error("waitrequest high without a request");
  a_read_upper: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_unmapped_zero: assert property (read && !waitrequest && address[1:0] != 2'h0
    |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  a_force_reads0: assert property (read && !waitrequest && address == TMR2_OFS_CTRL_B
    |-> readdata[7:6] == 2'h0)
    else $error("force strobe bits read back");
  a_irq_fall: assert property ((($past(irqReq) & ~irqReq) != 3'h0)
    |-> ($past(irqAck) != 3'h0) || $past(write && !waitrequest))
    else $error("request dropped without service or write");
  a_reset_quiet: assert property ($past(sys_rst)
    |-> irqReq == 3'h0 && !waveOutA && !waveOutB)
    else $error("outputs not zero after reset");
  a_osc_follow: assert property ($rose(oscPinIn) |-> ##[1:4] !oscPinOut)
    else $error("oscillator output not inverse of pin");

  // Main scenarios reached
  c_read_done: cover property (read && !waitrequest);
  c_match_a: cover property ($rose(irqReq[1]));
  c_wave_a: cover property ($rose(waveOutA));
endmodule

bind tmr2_timer tmr2_checker u_chk (.clk(clk), .sys_rst(sys_rst), .address(address),
  .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
  .oscPinIn(oscPinIn), .oscPinOut(oscPinOut), .irqAck(irqAck), .irqReq(irqReq),
  .waveOutA(waveOutA), .waveOutB(waveOutB));

// file: sim/tmr2_timer_tb.sv
// Self-checking testbench of the 8-bit timer over its Avalon-MM slave
`timescale 1ns/1ps
`define CHK(nm, e, g) begin nChecks++; if ((g) !== (e)) begin nFail++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module tmr2_timer_tb
  import tmr2_pkg::*;
;
  logic        clk, sys_rst, read, write, waitrequest, oscPinIn, oscPinOut;
  logic        waveOutA, waveOutB, svcEn;
  logic [4:0]  address;
  logic [3:0]  byteenable;
  logic [31:0] writedata, readdata, q;
  logic [2:0]  irqAck, irqReq;
  logic [1:0]  acts [5];
  logic [4:0]  pins [5];
  int          nFail, nChecks;

  tmr2_timer dut (.clk(clk), .sys_rst(sys_rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .oscPinIn(oscPinIn), .oscPinOut(oscPinOut),
    .irqAck(irqAck), .irqReq(irqReq), .waveOutA(waveOutA), .waveOutB(waveOutB));
  tmr2_cpu_model #(.DELAY(3)) model (.clk(clk), .sys_rst(sys_rst), .enable(svcEn),
    .irqReq(irqReq), .irqAck(irqAck));

  // Free-running bus clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Verdict and end of run
  task automatic reportAndStop();
    $display("checks %0d failures %0d", nChecks, nFail);
    if (nFail == 0 && nChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // One bus access held until waitrequest is sampled low at a rising edge
  // Read right after the edge, signals still show their pre-edge values
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    read <= ~w;
    write <= w;
    address <= a;
    writedata <= {24'h0, d};
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 20)
    begin
      n++;
      @(posedge clk);
    end
    if (waitrequest !== 1'b0)
    begin
      nFail++;
      reportAndStop();
    end
    else
    begin
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask

  task automatic chkRd(input logic [4:0] a, input logic [7:0] e, input string nm);
    acc(1'b0, a, 8'h00);
    `CHK(nm, e, q[7:0])
  endtask

  // Compare requests and wave outputs where settled
  task automatic chkPins(input logic [4:0] e, input string nm);
    @(negedge clk);
    `CHK(nm, e, {irqReq, waveOutA, waveOutB})
    @(posedge clk);
  endtask

  task automatic run(input logic [7:0] cb, input int n);
    wr(TMR2_OFS_CTRL_B, cb | 8'h01);
    repeat (n) @(posedge clk);
    wr(TMR2_OFS_CTRL_B, cb);
  endtask

  // Main sequence
  initial
  begin
    sys_rst = 1'b1;
    {read, write, oscPinIn, svcEn} = 4'h0;
    address = 5'h00;
    writedata = 32'h0;
    byteenable = 4'h1;
    nFail = 0;
    nChecks = 0;
    acts = '{2'h1, 2'h0, 2'h2, 2'h3, 2'h1};
    pins = '{5'h02, 5'h02, 5'h00, 5'h02, 5'h00};
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 8; i++)
      chkRd(5'(i * 4), 8'h00, "reset value");
    chkRd(5'h02, 8'h00, "unmapped read");
    wr(TMR2_OFS_COUNT, 8'h5a);
    byteenable <= 4'h0;
    wr(TMR2_OFS_COUNT, 8'h11);
    byteenable <= 4'h1;
    repeat (20) @(posedge clk);
    chkRd(TMR2_OFS_COUNT, 8'h5a, "stopped count");
    // Overflow and zero matches, masked then enabled, then write-one clear
    wr(TMR2_OFS_COUNT, 8'hfd);
    run(8'h00, 10);
    chkRd(TMR2_OFS_IRQ_FLAG, 8'h07, "wrap flags");
    chkPins(5'h00, "masked request");
    wr(TMR2_OFS_IRQ_MASK, 8'h01);
    chkPins(5'h04, "overflow request");
    wr(TMR2_OFS_IRQ_FLAG, 8'h07);
    chkPins(5'h00, "cleared request");
    // Count write blocks the match of the next tick only
    for (int i = 0; i < 2; i++)
    begin
      wr(TMR2_OFS_CMP_A, i ? 8'h12 : 8'h10);
      wr(TMR2_OFS_COUNT, 8'h10); // deliberately equal on the first pass
      run(8'h00, 6);
      chkRd(TMR2_OFS_IRQ_FLAG, i ? 8'h02 : 8'h00, "blocked match");
      wr(TMR2_OFS_IRQ_FLAG, 8'h07);
    end
    // Serviced interrupt clears its flag
    wr(TMR2_OFS_IRQ_MASK, 8'h02);
    wr(TMR2_OFS_COUNT, 8'h10);
    svcEn <= 1'b1;
    run(8'h00, 6);
    repeat (8) @(posedge clk);
    chkRd(TMR2_OFS_IRQ_FLAG, 8'h00, "serviced flag");
    svcEn <= 1'b0;
    wr(TMR2_OFS_IRQ_MASK, 8'h00);
    // Force strobe under each output action, new action used at once
    for (int i = 0; i < 5; i++)
    begin
      wr(TMR2_OFS_CTRL_A, {acts[i], 6'h00});
      wr(TMR2_OFS_CTRL_B, 8'h80);
      chkPins(pins[i], "forced output");
    end
    wr(TMR2_OFS_CTRL_A, 8'h70);
    wr(TMR2_OFS_CTRL_B, 8'h40);
    chkPins(5'h01, "forced output b");
    chkRd(TMR2_OFS_IRQ_FLAG, 8'h00, "force sets no flag");
    wr(TMR2_OFS_CTRL_B, 8'h80);
    chkPins(5'h03, "toggle again");
    wr(TMR2_OFS_CTRL_A, 8'hb3);
    chkPins(5'h03, "mode change hold");
    wr(TMR2_OFS_CTRL_B, 8'h80);
    chkPins(5'h03, "no force in pwm");
    // Fast PWM buffers compare B until top, normal mode writes through
    wr(TMR2_OFS_CTRL_A, 8'h03);
    wr(TMR2_OFS_CMP_B, 8'h22);
    chkRd(TMR2_OFS_CMP_B, 8'h22, "buffer readback");
    wr(TMR2_OFS_COUNT, 8'h20);
    run(8'h00, 6);
    chkRd(TMR2_OFS_IRQ_FLAG, 8'h00, "buffered compare");
    run(8'h00, 300);
    chkRd(TMR2_OFS_IRQ_FLAG, 8'h07, "loaded at top");
    wr(TMR2_OFS_IRQ_FLAG, 8'h07);
    wr(TMR2_OFS_CTRL_A, 8'h00);
    wr(TMR2_OFS_CMP_B, 8'h23);
    wr(TMR2_OFS_COUNT, 8'h20);
    run(8'h00, 6);
    chkRd(TMR2_OFS_IRQ_FLAG, 8'h04, "direct compare");
    // Modes 2 and 7 keep the count at or below compare A
    for (int i = 0; i < 2; i++)
    begin
      wr(TMR2_OFS_CTRL_A, i ? 8'h03 : 8'h02);
      wr(TMR2_OFS_CMP_A, 8'h05);
      wr(TMR2_OFS_COUNT, 8'h00);
      run(i ? 8'h08 : 8'h00, 40);
      acc(1'b0, TMR2_OFS_COUNT, 8'h00);
      `CHK("top from compare a", 1'b1, q[7:0] <= 8'h05)
    end
    // Phase correct mode turns at top and counts down
    wr(TMR2_OFS_CTRL_A, 8'h01);
    wr(TMR2_OFS_COUNT, 8'hfd);
    run(8'h00, 6);
    chkRd(TMR2_OFS_COUNT, 8'hf8, "dual slope count");
    // Oscillator clock: idle pin holds the count, five edges add five
    wr(TMR2_OFS_CTRL_A, 8'h00);
    wr(TMR2_OFS_ASYNC, 8'h20);
    wr(TMR2_OFS_COUNT, 8'h40);
    wr(TMR2_OFS_CTRL_B, 8'h01);
    repeat (30) @(posedge clk);
    chkRd(TMR2_OFS_COUNT, 8'h40, "idle oscillator");
    repeat (5)
    begin
      oscPinIn <= 1'b1;
      repeat (4) @(posedge clk);
      oscPinIn <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (6) @(posedge clk);
    chkRd(TMR2_OFS_COUNT, 8'h45, "oscillator count");
    reportAndStop();
  end
endmodule
